// File: src/pll_cfg_pkg.sv
package pll_cfg_pkg;
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_THIS_WORD = 2'h0;
  localparam int PREDIV_LSB = 2;
  localparam int PREDIV_W = 10;
  localparam int FBDIV_LSB = 12;
  localparam int FBDIV_W = 12;
  localparam int REF_DLY_LSB = 24;
  localparam int FB_DLY_LSB = 27;
  localparam int DLY_W = 3;
  localparam int AUTO_BIT = 30;
  localparam int DETECT_OFF_BIT = 31;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] PREDIV_RST = 10'h07F;
  localparam logic [11:0] FBDIV_RST = 12'h07F;
  localparam logic [2:0] DLY_RST = 3'h0;
  localparam logic AUTO_RST = 1'b0;
  localparam logic DETECT_OFF_RST = 1'b0;
  localparam logic [5:0] BITS_FULL = 6'h20;
  localparam logic [5:0] BITS_ONE = 6'h01;
  localparam logic [5:0] BITS_ZERO = 6'h00;
endpackage : pll_cfg_pkg

// File: src/serial_word_rx.sv
`timescale 1ns/100ps
// Shift register on the serial clock; word handed over by toggle on load rise
module serial_word_rx (
  // Serial link
  input wire logic sclk,
  input wire logic rst,
  input wire logic sdata,
  input wire logic load_n_window,
  // Captured word, held stable between toggles
  output logic [pll_cfg_pkg::WORD_W-1:0] word_q,
  output logic [5:0] count_q,
  output logic done_tgl_q
);
  import pll_cfg_pkg::*;

  logic [WORD_W-1:0] shift_q, shift_d;
  logic [WORD_W-1:0] word_d;
  logic [5:0] count_d;
  logic seen_tgl_q, seen_tgl_d;
  logic frame_tgl_q;
  logic done_tgl_d;
  logic load_rise_clk;
  logic frame_full;

  // Load-enable rise clocks the handover flops
  assign load_rise_clk = ~load_n_window;

  // Shift MSB first while load-enable is low; count restarts in each new window
  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    seen_tgl_d = seen_tgl_q;
    if (load_n_window) begin // see RULE_10
      shift_d = {shift_q[WORD_W-2:0], sdata};
      seen_tgl_d = frame_tgl_q;
      if (seen_tgl_q != frame_tgl_q) begin
        count_d = BITS_ONE;
      end else if (count_q != BITS_FULL) begin
        count_d = count_q + BITS_ONE;
      end
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      count_q <= BITS_ZERO;
      seen_tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
      seen_tgl_q <= seen_tgl_d;
    end
  end

  // Full word seen in this window; an empty window keeps the old tag
  assign frame_full = (count_q == BITS_FULL) && (seen_tgl_q == frame_tgl_q);

  // Short frames leave word and toggle alone
  always_comb begin
    word_d = word_q;
    done_tgl_d = done_tgl_q;
    if (frame_full) begin // see RULE_10
      word_d = shift_q;
      done_tgl_d = ~done_tgl_q;
    end
  end

  // Snapshot on load rise: asynchronous handover of the word
  always_ff @(posedge load_rise_clk or posedge rst) begin
    if (rst) begin
      word_q <= '0;
      done_tgl_q <= 1'b0;
      frame_tgl_q <= 1'b0;
    end else begin
      word_q <= word_d; // see RULE_12
      done_tgl_q <= done_tgl_d;
      frame_tgl_q <= ~frame_tgl_q;
    end
  end
endmodule : serial_word_rx

// File: src/pll_divider_config_word.sv
`timescale 1ns/100ps
//
// Contract
// RULE_01 - Pre-divider bits 2..11, reset 0x07F
// RULE_02 - Feedback divider bits 12..23, reset 0x07F
// RULE_03 - Reference delay code bits 24..26, reset zero
// RULE_04 - Feedback delay code bits 27..29, reset zero
// RULE_05 - Bit 30 selects automatic reference switching
// RULE_06 - Bit 31 disables frequency detection
// RULE_07 - Detection off forces status high
// RULE_08 - Detection on passes detector status
// RULE_09 - Host keeps feedback divider input below 300MHz
// RULE_10 - 32 bits MSB first, sampled while low
// RULE_11 - Low two bits zero select this word
// RULE_12 - Load-enable rise commits; high blocks transfer
// RULE_13 - Write only, no readback or handshake
// RULE_14 - Delay codes forwarded as opaque values
module pll_divider_config_word (
  // System
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Serial write link
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic SERIAL_LOAD_ENABLE,
  // Reference detector
  input wire logic REF_FREQ_OK,
  // Configuration outputs
  output logic [pll_cfg_pkg::PREDIV_W-1:0] REF_PREDIVIDER,
  output logic [pll_cfg_pkg::FBDIV_W-1:0] FEEDBACK_DIVIDER,
  output logic [pll_cfg_pkg::DLY_W-1:0] REFERENCE_PHASE_DELAY,
  output logic [pll_cfg_pkg::DLY_W-1:0] FEEDBACK_PHASE_DELAY,
  output logic REFERENCE_SELECT_AUTO,
  output logic FREQ_DETECT_DISABLE,
  output logic REF_STATUS
);
  import pll_cfg_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // True when a received word addresses this register
  function automatic logic sel_match(input logic [WORD_W-1:0] w);
    return w[SEL_LSB +: SEL_W] == SEL_THIS_WORD;
  endfunction : sel_match

  // Second and third sync stages agree
  function automatic logic sync_settled(input logic [2:0] s);
    return s[2] == s[1];
  endfunction : sync_settled

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic [WORD_W-1:0] rx_word;
  logic rx_tgl;

  // Accepts bits only while load-enable is low
  serial_word_rx u_rx (
    .sclk(SER_CLK),
    .rst(RST),
    .sdata(SER_DATA),
    .load_n_window(~SERIAL_LOAD_ENABLE), // see RULE_12
    .word_q(rx_word),
    .count_q(),
    .done_tgl_q(rx_tgl)
  );

  // ----------------------------------------
  // Crossing into MCLK
  // ----------------------------------------
  logic [2:0] tgl_sync_q, tgl_sync_d;
  logic tgl_seen_q, tgl_seen_d;
  logic word_new;

  // Toggle from the link: three stages, counted once stages two and three agree
  always_comb begin
    tgl_sync_d = {tgl_sync_q[1:0], rx_tgl};
    tgl_seen_d = sync_settled(tgl_sync_q) ? tgl_sync_q[2] : tgl_seen_q;
  end

  // Sync stages freeze with the clock enable
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tgl_sync_q <= '0;
      tgl_seen_q <= 1'b0;
    end else if (CE) begin
      tgl_sync_q <= tgl_sync_d;
      tgl_seen_q <= tgl_seen_d;
    end
  end

  // Word held still in the link domain until the next toggle
  assign word_new = sync_settled(tgl_sync_q) && (tgl_sync_q[2] != tgl_seen_q);

  // ----------------------------------------
  // Reference detector input
  // ----------------------------------------
  logic [2:0] ok_sync_q, ok_sync_d;
  logic ok_stable_q, ok_stable_d;

  // Detector level: change counted once stages two and three agree
  always_comb begin
    ok_sync_d = {ok_sync_q[1:0], REF_FREQ_OK};
    ok_stable_d = sync_settled(ok_sync_q) ? ok_sync_q[2] : ok_stable_q;
  end

  // Filtered level starts low, as the status does
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ok_sync_q <= '0;
      ok_stable_q <= 1'b0;
    end else if (CE) begin
      ok_sync_q <= ok_sync_d;
      ok_stable_q <= ok_stable_d;
    end
  end

  // ----------------------------------------
  // Word commit
  // ----------------------------------------
  logic commit;

  // Only words addressed to this register; write only, no readback
  assign commit = word_new && sel_match(rx_word); // see RULE_11 see RULE_13

  // ----------------------------------------
  // Reference pre-divider
  // ----------------------------------------
  logic [PREDIV_W-1:0] prediv_q, prediv_d;

  // Field taken whole from the committed word
  always_comb begin
    prediv_d = prediv_q;
    if (commit) begin
      prediv_d = rx_word[PREDIV_LSB +: PREDIV_W]; // see RULE_01
    end
  end

  // Seven low bits come up set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prediv_q <= PREDIV_RST; // see RULE_01
    end else if (CE) begin
      prediv_q <= prediv_d;
    end
  end

  // ----------------------------------------
  // Feedback divider
  // ----------------------------------------
  logic [FBDIV_W-1:0] fbdiv_q, fbdiv_d;

  // Field taken whole from the committed word
  always_comb begin
    fbdiv_d = fbdiv_q;
    if (commit) begin
      fbdiv_d = rx_word[FBDIV_LSB +: FBDIV_W]; // see RULE_02
    end
  end

  // Seven low bits come up set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      fbdiv_q <= FBDIV_RST; // see RULE_02
    end else if (CE) begin
      fbdiv_q <= fbdiv_d;
    end
  end

  // ----------------------------------------
  // Phase-delay codes
  // ----------------------------------------
  logic [DLY_W-1:0] rdly_q, rdly_d, fdly_q, fdly_d;

  // Codes kept as given; step size is the delay logic's business
  always_comb begin
    rdly_d = rdly_q;
    fdly_d = fdly_q;
    if (commit) begin
      rdly_d = rx_word[REF_DLY_LSB +: DLY_W]; // see RULE_03
      fdly_d = rx_word[FB_DLY_LSB +: DLY_W]; // see RULE_04
    end
  end

  // Both codes come up zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdly_q <= DLY_RST;
      fdly_q <= DLY_RST;
    end else if (CE) begin
      rdly_q <= rdly_d;
      fdly_q <= fdly_d;
    end
  end

  // ----------------------------------------
  // Mode bits
  // ----------------------------------------
  logic auto_q, auto_d, doff_q, doff_d;

  // Reference selection mode and detection switch
  always_comb begin
    auto_d = auto_q;
    doff_d = doff_q;
    if (commit) begin
      auto_d = rx_word[AUTO_BIT]; // see RULE_05
      doff_d = rx_word[DETECT_OFF_BIT]; // see RULE_06
    end
  end

  // Detection comes up active
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      auto_q <= AUTO_RST;
      doff_q <= DETECT_OFF_RST; // see RULE_06
    end else if (CE) begin
      auto_q <= auto_d;
      doff_q <= doff_d;
    end
  end

  // ----------------------------------------
  // Reference status
  // ----------------------------------------
  logic status_q, status_d;

  // Detection off wins at once over the detector
  always_comb begin
    status_d = doff_d ? 1'b1 : ok_stable_d; // see RULE_07 see RULE_08
  end

  // Low during reset, as the filtered level
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      status_q <= 1'b0;
    end else if (CE) begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Opaque delay codes straight to delay logic
  assign REF_PREDIVIDER = prediv_q;
  assign FEEDBACK_DIVIDER = fbdiv_q;
  assign REFERENCE_PHASE_DELAY = rdly_q; // see RULE_14
  assign FEEDBACK_PHASE_DELAY = fdly_q; // see RULE_14
  assign REFERENCE_SELECT_AUTO = auto_q;
  assign FREQ_DETECT_DISABLE = doff_q;
  assign REF_STATUS = status_q;
endmodule : pll_divider_config_word

// File: verif/pll_cfg_chk_sva.sv
`timescale 1ns/100ps
module pll_cfg_chk
  import pll_cfg_pkg::*;
(
  // Clock, reset, inputs
  input logic MCLK,
  input logic RST,
  input logic SERIAL_LOAD_ENABLE,
  input logic REF_FREQ_OK,
  // Outputs
  input logic [9:0] REF_PREDIVIDER,
  input logic [11:0] FEEDBACK_DIVIDER,
  input logic [2:0] REFERENCE_PHASE_DELAY,
  input logic [2:0] FEEDBACK_PHASE_DELAY,
  input logic REFERENCE_SELECT_AUTO,
  input logic FREQ_DETECT_DISABLE,
  input logic REF_STATUS
);
  logic [31:0] cfg;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Packed word view
  assign cfg = {FREQ_DETECT_DISABLE, REFERENCE_SELECT_AUTO, FEEDBACK_PHASE_DELAY,
    REFERENCE_PHASE_DELAY, FEEDBACK_DIVIDER, REF_PREDIVIDER, 2'h0};
  pdiv_rst_a: assert property ($fell(RST) |-> cfg[11:2] == PREDIV_RST)
    else $error("prediv reset");
  fdiv_rst_a: assert property ($fell(RST) |-> cfg[23:12] == FBDIV_RST)
    else $error("fbdiv reset");
  dly_rst_a: assert property ($fell(RST) |-> cfg[29:24] == 6'h00)
    else $error("delay reset");
  mode_rst_a: assert property ($fell(RST) |-> cfg[31:30] == 2'h0)
    else $error("mode reset");
  load_wait_a: assert property ($rose(SERIAL_LOAD_ENABLE) |=> $stable(cfg)[*2])
    else $error("early update");
  stat_off_a: assert property (
    FREQ_DETECT_DISABLE && $past(FREQ_DETECT_DISABLE) |-> REF_STATUS) else $error("status off");
  stat_low_a: assert property (
    (!FREQ_DETECT_DISABLE && !REF_FREQ_OK)[*8] |-> !REF_STATUS) else $error("status low");
  stat_high_a: assert property (
    (!FREQ_DETECT_DISABLE && REF_FREQ_OK)[*8] |-> REF_STATUS) else $error("status high");
  cover property ($rose(SERIAL_LOAD_ENABLE));
  cover property (FREQ_DETECT_DISABLE && !REF_FREQ_OK);
  cover property ($fell(REF_STATUS));
  cover property ($changed(REF_PREDIVIDER));
endmodule : pll_cfg_chk
bind pll_divider_config_word pll_cfg_chk u_pll_cfg_chk (.MCLK, .RST, .SERIAL_LOAD_ENABLE,
  .REF_FREQ_OK, .REF_PREDIVIDER, .FEEDBACK_DIVIDER, .REFERENCE_PHASE_DELAY,
  .FEEDBACK_PHASE_DELAY, .REFERENCE_SELECT_AUTO, .FREQ_DETECT_DISABLE, .REF_STATUS);

// File: verif/host_ser_model.sv
`timescale 1ns/100ps
// Write-only host, no read path
module host_ser_model (
  // Serial lines
  output logic sclk,
  output logic sdata,
  output logic le_n
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    le_n = 1'b1;
  end
  // Feedback prescale lives in another word; host keeps it legal
  // Clock idles low between frames; odd start offset breaks phase with MCLK
  task automatic send(input logic [31:0] w, input int nb);
    #7.3;
    le_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      sdata = w[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 le_n = 1'b1;
    sdata = ~sdata;
    #200;
  endtask : send
endmodule : host_ser_model

// File: verif/pll_divider_config_word_tb.sv
`timescale 1ns/100ps
module pll_divider_config_word_tb;
  import pll_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ok = 1'b1;
  logic ce = 1'b1;
  logic sclk, sdata, le_n, au, dd, st;
  logic [9:0] pd;
  logic [11:0] fb;
  logic [2:0] rd, fd;
  logic [31:0] wl [3] = '{32'hFFFF_FFFC, 32'hAAAA_AAA8, 32'h0123_4568};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  host_ser_model u_host_ser_model (.sclk(sclk), .sdata(sdata), .le_n(le_n));
  pll_divider_config_word u_pll_divider_config_word (.MCLK(mclk), .RST(rst), .CE(ce),
    .SER_CLK(sclk), .SER_DATA(sdata), .SERIAL_LOAD_ENABLE(le_n), .REF_FREQ_OK(ok),
    .REF_PREDIVIDER(pd), .FEEDBACK_DIVIDER(fb), .REFERENCE_PHASE_DELAY(rd),
    .FEEDBACK_PHASE_DELAY(fd), .REFERENCE_SELECT_AUTO(au), .FREQ_DETECT_DISABLE(dd),
    .REF_STATUS(st));
  // Compare word or status on a falling edge
  task automatic chk(input string nm, input logic [31:0] exp);
    logic [31:0] got;
    @(negedge mclk);
    got = (nm == "st") ? {31'h0, st} : {dd, au, fd, rd, fb, pd, 2'h0};
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    chk("cfg", {8'h00, FBDIV_RST, PREDIV_RST, 2'h0});
    repeat (10) @(negedge mclk);
    chk("st", 32'h1);
    foreach (wl[i]) begin
      u_host_ser_model.send(wl[i], 32);
      chk("cfg", wl[i]);
    end
    for (int s = 1; s < 4; s++) begin
      u_host_ser_model.send({30'h1234, s[1:0]}, 32);
      chk("cfg", wl[2]);
    end
    u_host_ser_model.send(32'h0, 31);
    chk("cfg", wl[2]);
    @(negedge mclk) ok = 1'b0;
    repeat (10) @(negedge mclk);
    chk("st", 32'h0);
    // Clock enable low freezes the commit; it lands once enable returns
    @(negedge mclk) ce = 1'b0;
    u_host_ser_model.send(32'h0246_8AC0, 32);
    chk("cfg", wl[2]);
    @(negedge mclk) ce = 1'b1;
    repeat (5) @(negedge mclk);
    chk("cfg", 32'h0246_8AC0);
    u_host_ser_model.send(32'h8123_4568, 32);
    chk("st", 32'h1);
    summarize();
  end
endmodule : pll_divider_config_word_tb
